// ---- shared/reading_math_defines.svh ----
`ifndef READING_MATH_DEFINES_SVH
`define READING_MATH_DEFINES_SVH

`define NUM_INPUTS   2
`define NUM_SOURCES  3

// register byte offsets inside one input's block, block stride, command word
`define OFF_CFG      8'h00
`define OFF_GAIN     8'h04
`define OFF_OFFS     8'h08
`define OFF_FSCALE   8'h0c
`define OFF_MAX      8'h10
`define OFF_MIN      8'h14
`define OFF_LIN      8'h18
`define OFF_STAT     8'h1c
`define CH_STRIDE    8'h20
`define OFF_CMD      8'h40

// configuration word fields
`define CFG_W        20
`define CFG_MM_LSB   0
`define CFG_X_LSB    2
`define CFG_EQ_BIT   4
`define CFG_B_LSB    5
`define CFG_EN_BIT   8
`define CFG_PTS_LSB  9
`define CFG_WIN_LSB  16

// source codes
`define SRC_KELVIN   2'h0
`define SRC_CELSIUS  2'h1
`define SRC_SENSOR   2'h2
`define SRC_LINEAR   2'h3
`define B_VALUE      3'h0
`define B_SP1_POS    3'h1
`define B_SP1_NEG    3'h2
`define B_SP2_POS    3'h3
`define B_SP2_NEG    3'h4

// limits and reset values
`define PTS_MIN      7'h02
`define PTS_MAX      7'h40
`define PTS_DEF      7'h08
`define WIN_MIN      4'h1
`define WIN_MAX      4'ha
`define WIN_DEF      4'h1
`define PCT_DIV      64'h0000_0000_0000_0064
`define Q_ONE        17'h10000
`define Q_FRAC       16
`define GAIN_RESET   32'h0000_0000
`define OFFS_RESET   32'h0000_0000
`define FSCALE_RESET 32'h0001_86a0

`endif

// ---- shared/reading_math_pkg.sv ----
package reading_math_pkg;

   typedef struct packed {
      logic        valid;
      logic [31:0] kelvin;
      logic [31:0] celsius;
      logic [31:0] sensor;
   } reading_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] value;
   } linear_t;

   typedef struct packed {
      logic        seen;
      logic [31:0] max;
      logic [31:0] min;
   } extreme_t;

endpackage : reading_math_pkg

// ---- logic/ema_stage.sv ----
`timescale 1ns/1ps
`include "reading_math_defines.svh"

module ema_stage (
   input  wire logic        core_clk_in,
   input  wire logic        rst_in,
   input  wire logic        restart_in,
   input  wire logic        enable_in,
   input  wire logic [16:0] recip_in,
   input  wire logic [31:0] thresh_in,
   input  wire logic        sample_valid_in,
   input  wire logic [31:0] sample_in,
   output logic      [31:0] value_out
);
   import reading_math_pkg::*;

   logic signed [47:0] acc_reg, acc_next;
   logic               primed_reg, primed_next;
   logic signed [32:0] diff;
   logic        [32:0] mag;
   logic signed [48:0] delta;
   logic signed [66:0] prod;
   logic signed [66:0] step;

   always_comb begin
      diff  = $signed({sample_in[31], sample_in}) - $signed({acc_reg[47], acc_reg[47:16]});
      mag   = diff[32] ? 33'(-diff) : 33'(diff);
      delta = $signed({sample_in[31], sample_in, 16'h0000}) - $signed({acc_reg[47], acc_reg});
      prod  = delta * $signed({1'b0, recip_in});
      step  = prod >>> `Q_FRAC;
      acc_next    = acc_reg;
      primed_next = primed_reg;
      if (sample_valid_in) begin
         // a sample in the same cycle as a restart is kept: it seeds the new average
         if (!enable_in || !primed_reg || restart_in || mag > {1'b0, thresh_in}) begin
            acc_next    = $signed({sample_in, 16'h0000});
            primed_next = enable_in;
         end else begin
            acc_next    = acc_reg + step[47:0];
         end
      end else if (restart_in) begin
         primed_next = 1'b0;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         acc_reg    <= 48'h0000_0000_0000;
         primed_reg <= 1'b0;
         value_out  <= 32'h0000_0000;
      end else begin
         acc_reg    <= acc_next;
         primed_reg <= primed_next;
         value_out  <= acc_next[47:16];
      end
   end

endmodule : ema_stage

// ---- logic/reading_math_processor.sv ----
//
// Operation
// - keep largest and smallest selected-source value since last clear, per input
// - tracker follows one source: kelvin, celsius, sensor units or linear result
// - tracking runs on every reading, no enable
// - clear extremes on power-up, input parameter change, or math-clear command
// - math-clear touches only the extremes, never the settings
// - linear form is gain*x+offset or gain*(x+offset), selectable
// - linear result goes to display and analog output
// - mismatched units still compute, no error
// - enabled filter smooths every reading value of the input
// - running average, one output per reading
// - control loops get unfiltered readings, all features get filtered ones
// - filter length 2 to 64 points, default 8
// - a reading beyond the window from the filter value restarts the filter
// - window is 1 to 10 percent of full scale, default 1
// - default length settles in about 50 readings
// - each input has its own independent settings
// - settings accepted before an abandoned setup are kept
//
`timescale 1ns/1ps
`include "reading_math_defines.svh"

module reading_math_processor (
   input  wire logic                             core_clk_in,
   input  wire logic                             rst_in,
   input  wire logic                             psel_in,
   input  wire logic                             penable_in,
   input  wire logic                             pwrite_in,
   input  wire logic [7:0]                       paddr_in,
   input  wire logic [31:0]                      pwdata_in,
   output logic      [31:0]                      prdata_out,
   output logic                                  pready_out,
   output logic                                  pslverr_out,
   input  wire logic [31:0]                      loop_one_setpoint_in,
   input  wire logic [31:0]                      loop_two_setpoint_in,
   input  wire reading_math_pkg::reading_t [1:0] reading_in,
   input  wire logic [1:0]                       input_change_in,
   output reading_math_pkg::reading_t [1:0]      control_reading_out,
   output reading_math_pkg::reading_t [1:0]      filtered_out,
   output reading_math_pkg::linear_t [1:0]       linear_out,
   output reading_math_pkg::extreme_t [1:0]      extreme_out
);
   import reading_math_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // helpers

   // the command word sits right after the second block and reads back as zero
   function automatic logic is_mapped(input logic [7:0] addr);
      is_mapped = (addr[1:0] == 2'h0) && ((addr < `OFF_CMD) || (addr == `OFF_CMD));
   endfunction : is_mapped

   // out-of-range length and window are pulled to the nearest legal value; a bad b or x source falls back to code 0
   function automatic logic [`CFG_W-1:0] cfg_clean(input logic [31:0] w);
      logic [`CFG_W-1:0] c;
      c = w[`CFG_W-1:0];
      if (w[`CFG_PTS_LSB +: 7] < `PTS_MIN) c[`CFG_PTS_LSB +: 7] = `PTS_MIN;
      if (w[`CFG_PTS_LSB +: 7] > `PTS_MAX) c[`CFG_PTS_LSB +: 7] = `PTS_MAX;
      if (w[`CFG_WIN_LSB +: 4] < `WIN_MIN) c[`CFG_WIN_LSB +: 4] = `WIN_MIN;
      if (w[`CFG_WIN_LSB +: 4] > `WIN_MAX) c[`CFG_WIN_LSB +: 4] = `WIN_MAX;
      if (w[`CFG_B_LSB +: 3] > `B_SP2_NEG) c[`CFG_B_LSB +: 3] = `B_VALUE;
      if (w[`CFG_X_LSB +: 2] == `SRC_LINEAR) c[`CFG_X_LSB +: 2] = `SRC_KELVIN;
      cfg_clean = c;
   endfunction : cfg_clean

   // smoothing weight 1/points in q16; at 8 points a step is within 0.2% after
   // about 50 readings
   function automatic logic [16:0] recip_of(input logic [`CFG_W-1:0] c);
      recip_of = 17'(`Q_ONE / {10'h000, c[`CFG_PTS_LSB +: 7]});
   endfunction : recip_of

   function automatic logic [31:0] thresh_of(input logic [`CFG_W-1:0] c,
                                             input logic [31:0]       fs);
      thresh_of = 32'((64'(fs) * 64'(c[`CFG_WIN_LSB +: 4])) / `PCT_DIV);
   endfunction : thresh_of

   ////////////////////////////////////////////////////////////////////////////////
   // register file

   logic [`CFG_W-1:0] cfg_reg    [2];
   logic [`CFG_W-1:0] cfg_next   [2];
   logic [31:0]       gain_reg   [2];
   logic [31:0]       gain_next  [2];
   logic [31:0]       offs_reg   [2];
   logic [31:0]       offs_next  [2];
   logic [31:0]       fs_reg     [2];
   logic [31:0]       fs_next    [2];
   logic [16:0]       recip_reg  [2];
   logic [16:0]       recip_next [2];
   logic [31:0]       thr_reg    [2];
   logic [31:0]       thr_next   [2];
   logic [1:0]        clr_reg, clr_next;
   logic [1:0]        chg_reg, chg_next;
   logic [31:0]       prdata_next;
   logic              pready_next;
   logic              pslverr_next;
   logic              ch_sel;
   logic [7:0]        word_off;
   logic              do_write;

   // no wait states: ready always follows setup by one clock, so the master
   // never stalls and every transfer costs exactly two cycles
   always_comb begin
      ch_sel       = paddr_in[5];
      word_off     = {3'h0, paddr_in[4:0]};
      do_write     = psel_in && penable_in && pready_out && pwrite_in;
      pready_next  = psel_in && !penable_in;
      prdata_next  = 32'h0000_0000;
      pslverr_next = 1'b0;
      clr_next     = 2'h0;
      chg_next     = 2'h0;
      for (int i = 0; i < `NUM_INPUTS; i++) begin
         cfg_next[i]   = cfg_reg[i];
         gain_next[i]  = gain_reg[i];
         offs_next[i]  = offs_reg[i];
         fs_next[i]    = fs_reg[i];
         recip_next[i] = recip_of(cfg_reg[i]);
         thr_next[i]   = thresh_of(cfg_reg[i], fs_reg[i]);
      end
      // read data and error are prepared in the setup cycle so the answer is a flop
      if (psel_in && !penable_in) begin
         pslverr_next = !is_mapped(paddr_in);
         if (is_mapped(paddr_in) && !pwrite_in && paddr_in < `OFF_CMD) begin
            unique case (word_off)
               `OFF_CFG:    prdata_next = {12'h000, cfg_reg[ch_sel]};
               `OFF_GAIN:   prdata_next = gain_reg[ch_sel];
               `OFF_OFFS:   prdata_next = offs_reg[ch_sel];
               `OFF_FSCALE: prdata_next = fs_reg[ch_sel];
               `OFF_MAX:    prdata_next = extreme_out[ch_sel].max;
               `OFF_MIN:    prdata_next = extreme_out[ch_sel].min;
               `OFF_LIN:    prdata_next = linear_out[ch_sel].value;
               default:     prdata_next = {31'h0000_0000, extreme_out[ch_sel].seen};
            endcase
         end
      end
      // every accepted write stands on its own, so a setup left halfway keeps it
      if (do_write && is_mapped(paddr_in)) begin
         if (paddr_in == `OFF_CMD) begin
            clr_next = pwdata_in[1:0];
         end else begin
            unique case (word_off)
               `OFF_CFG: begin
                  cfg_next[ch_sel] = cfg_clean(pwdata_in);
                  chg_next[ch_sel] = 1'b1;
               end
               `OFF_GAIN: begin
                  gain_next[ch_sel] = pwdata_in;
                  chg_next[ch_sel]  = 1'b1;
               end
               `OFF_OFFS: begin
                  offs_next[ch_sel] = pwdata_in;
                  chg_next[ch_sel]  = 1'b1;
               end
               `OFF_FSCALE: begin
                  fs_next[ch_sel]  = pwdata_in;
                  chg_next[ch_sel] = 1'b1;
               end
               default: ;
            endcase
         end
      end
      chg_next = chg_next | input_change_in;
   end

   // recip and threshold are registered to keep the divide off the filter path;
   // they trail a setting by one cycle, covered by the restart that write raises
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         for (int i = 0; i < `NUM_INPUTS; i++) begin
            cfg_reg[i]   <= `CFG_W'({`WIN_DEF, `PTS_DEF, 9'h000});
            gain_reg[i]  <= `GAIN_RESET;
            offs_reg[i]  <= `OFFS_RESET;
            fs_reg[i]    <= `FSCALE_RESET;
            recip_reg[i] <= 17'h00000;
            thr_reg[i]   <= 32'h0000_0000;
         end
         clr_reg     <= 2'h0;
         chg_reg     <= 2'h0;
         prdata_out  <= 32'h0000_0000;
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         cfg_reg     <= cfg_next;
         gain_reg    <= gain_next;
         offs_reg    <= offs_next;
         fs_reg      <= fs_next;
         recip_reg   <= recip_next;
         thr_reg     <= thr_next;
         clr_reg     <= clr_next;
         chg_reg     <= chg_next;
         prdata_out  <= prdata_next;
         pready_out  <= pready_next;
         pslverr_out <= pslverr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // per-input datapath

   for (genvar ch = 0; ch < `NUM_INPUTS; ch++) begin : g_input
      logic [31:0] filt_val [`NUM_SOURCES];
      logic [31:0] raw_val  [`NUM_SOURCES];
      logic [`CFG_W-1:0] c;
      reading_t    ctl_next;
      logic        fv_reg, fv_next;
      linear_t     lin_next;
      extreme_t    ext_next;
      logic        mm_valid;
      logic signed [31:0] x_op, b_op;
      logic signed [32:0] operand;
      logic signed [64:0] prod;
      logic signed [64:0] scaled;
      logic        [31:0] mm_src;

      assign c          = cfg_reg[ch];
      assign raw_val[0] = reading_in[ch].kelvin;
      assign raw_val[1] = reading_in[ch].celsius;
      assign raw_val[2] = reading_in[ch].sensor;

      for (genvar s = 0; s < `NUM_SOURCES; s++) begin : g_src
         ema_stage u_ema (
            .core_clk_in     (core_clk_in),
            .rst_in          (rst_in),
            .restart_in      (chg_reg[ch]),
            .enable_in       (c[`CFG_EN_BIT]),
            .recip_in        (recip_reg[ch]),
            .thresh_in       (thr_reg[ch]),
            .sample_valid_in (reading_in[ch].valid),
            .sample_in       (raw_val[s]),
            .value_out       (filt_val[s])
         );
      end

      always_comb begin
         ctl_next         = reading_in[ch];
         fv_next          = reading_in[ch].valid;
         unique case (c[`CFG_X_LSB +: 2])
            `SRC_CELSIUS: x_op = $signed(filt_val[1]);
            `SRC_SENSOR:  x_op = $signed(filt_val[2]);
            default:      x_op = $signed(filt_val[0]);
         endcase
         // setpoint units are not checked against x units
         unique case (c[`CFG_B_LSB +: 3])
            `B_SP1_POS: b_op = $signed(loop_one_setpoint_in);
            `B_SP1_NEG: b_op = -$signed(loop_one_setpoint_in);
            `B_SP2_POS: b_op = $signed(loop_two_setpoint_in);
            `B_SP2_NEG: b_op = -$signed(loop_two_setpoint_in);
            default:    b_op = $signed(offs_reg[ch]);
         endcase
         // one extra bit keeps x+b from wrapping before the multiply
         operand = c[`CFG_EQ_BIT] ? ({x_op[31], x_op} + {b_op[31], b_op})
                                  : {x_op[31], x_op};
         prod    = $signed(gain_reg[ch]) * operand;
         scaled  = prod >>> `Q_FRAC;
         lin_next.valid = fv_reg;
         lin_next.value = c[`CFG_EQ_BIT] ? scaled[31:0]
                                         : 32'(scaled[31:0] + b_op);
         if (!fv_reg) lin_next.value = linear_out[ch].value;
         // extremes run one stage behind the linear result so all four sources line up
         mm_valid = linear_out[ch].valid;
         unique case (c[`CFG_MM_LSB +: 2])
            `SRC_KELVIN:  mm_src = filtered_out[ch].kelvin;
            `SRC_CELSIUS: mm_src = filtered_out[ch].celsius;
            `SRC_SENSOR:  mm_src = filtered_out[ch].sensor;
            default:      mm_src = linear_out[ch].value;
         endcase
         ext_next = extreme_out[ch];
         if (clr_reg[ch] || chg_reg[ch]) ext_next.seen = 1'b0;
         // a reading in the clearing cycle survives: it becomes the new max and min
         if (mm_valid) begin
            if (!ext_next.seen || $signed(mm_src) > $signed(ext_next.max))
               ext_next.max = mm_src;
            if (!ext_next.seen || $signed(mm_src) < $signed(ext_next.min))
               ext_next.min = mm_src;
            ext_next.seen = 1'b1;
         end
      end

      always_ff @(posedge core_clk_in) begin
         if (rst_in) begin
            control_reading_out[ch] <= '0;
            fv_reg                  <= 1'b0;
            linear_out[ch]          <= '0;
            extreme_out[ch]         <= '0;
         end else begin
            control_reading_out[ch] <= ctl_next;
            fv_reg                  <= fv_next;
            linear_out[ch]          <= lin_next;
            extreme_out[ch]         <= ext_next;
         end
      end

      // the filter stages carry no valid of their own, so it is realigned here
      assign filtered_out[ch].valid   = fv_reg;
      assign filtered_out[ch].kelvin  = filt_val[0];
      assign filtered_out[ch].celsius = filt_val[1];
      assign filtered_out[ch].sensor  = filt_val[2];
   end

endmodule : reading_math_processor

// ---- sim/reading_math_properties.sv ----
`timescale 1ns/1ps
module reading_math_properties (
   input wire logic                             core_clk_in,
   input wire logic                             rst_in,
   input wire logic                             psel_in,
   input wire logic                             penable_in,
   input wire logic                             pwrite_in,
   input wire logic [7:0]                       paddr_in,
   input wire logic [31:0]                      pwdata_in,
   input wire logic [31:0]                      prdata_out,
   input wire logic                             pready_out,
   input wire logic                             pslverr_out,
   input wire logic [31:0]                      loop_one_setpoint_in,
   input wire logic [31:0]                      loop_two_setpoint_in,
   input wire reading_math_pkg::reading_t [1:0] reading_in,
   input wire logic [1:0]                       input_change_in,
   input wire reading_math_pkg::reading_t [1:0] control_reading_out,
   input wire reading_math_pkg::reading_t [1:0] filtered_out,
   input wire reading_math_pkg::linear_t [1:0]  linear_out,
   input wire reading_math_pkg::extreme_t [1:0] extreme_out
);
   import reading_math_pkg::*;
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);
   ////////////////////////////////////////
   pready_setup_a: assert property (psel_in && !penable_in |=> pready_out)
      else $error("no ready after setup");
   pready_once_a: assert property (pready_out |=> !pready_out)
      else $error("ready longer than one cycle");
   slverr_ready_a: assert property (pslverr_out |-> pready_out)
      else $error("error without ready");
   prdata_idle_a: assert property (!pready_out |-> prdata_out == 32'h0)
      else $error("read data outside access");
   ////////////////////////////////////////
   ctl_raw_a: assert property (
      reading_in[0].valid |=> control_reading_out[0] == $past(reading_in[0]))
      else $error("control reading not raw");
   ctl_raw_one_a: assert property (
      reading_in[1].valid |=> control_reading_out[1] == $past(reading_in[1]))
      else $error("control reading not raw on second input");
   filt_rate_a: assert property (reading_in[0].valid |=> filtered_out[0].valid)
      else $error("filter dropped a reading");
   filt_single_a: assert property (filtered_out[0].valid |-> $past(reading_in[0].valid))
      else $error("filter output without reading");
   lin_rate_a: assert property (reading_in[1].valid |-> ##2 linear_out[1].valid)
      else $error("linear result missing");
   ext_order_a: assert property (
      extreme_out[0].seen |-> $signed(extreme_out[0].max) >= $signed(extreme_out[0].min))
      else $error("max below min");
   ext_seed_a: assert property ($rose(extreme_out[0].seen) |-> $past(linear_out[0].valid))
      else $error("extremes set without reading");
   // extremes may only move on the edge after a reading reached the tracker
   ext_hold_a: assert property (
      extreme_out[0].seen && $past(extreme_out[0].seen) && !$past(linear_out[0].valid) |->
      $stable(extreme_out[0].max) && $stable(extreme_out[0].min))
      else $error("extremes moved without reading");
   // a clear landing with a reading may restart max lower, so clears are left out
   ext_grow_a: assert property (
      extreme_out[0].seen && $past(extreme_out[0].seen) && !$past(penable_in, 2) &&
      !$past(input_change_in[0], 2) |->
      $signed(extreme_out[0].max) >= $signed($past(extreme_out[0].max)))
      else $error("max decreased");
endmodule : reading_math_properties

bind reading_math_processor reading_math_properties reading_math_properties_inst (
   .core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel_in),
   .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
   .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
   .pslverr_out(pslverr_out), .loop_one_setpoint_in(loop_one_setpoint_in),
   .loop_two_setpoint_in(loop_two_setpoint_in), .reading_in(reading_in),
   .input_change_in(input_change_in), .control_reading_out(control_reading_out),
   .filtered_out(filtered_out), .linear_out(linear_out), .extreme_out(extreme_out)
);

// ---- sim/reading_source_model.sv ----
`timescale 1ns/1ps
module reading_source_model (
   input  wire logic                        core_clk_in,
   output reading_math_pkg::reading_t [1:0] reading_out
);
   import reading_math_pkg::*;
   initial reading_out = '0;
   // fields are inverted after the pulse so no one can lean on stale data
   task automatic send(input int ch, input logic [31:0] k, c, s, input int gap);
      reading_out[ch] <= '{1'b1, k, c, s};
      @(posedge core_clk_in);
      reading_out[ch] <= '{1'b0, ~k, ~c, ~s};
      repeat (gap) @(posedge core_clk_in);
   endtask : send
endmodule : reading_source_model

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`include "reading_math_defines.svh"
module tb_top;
   import reading_math_pkg::*;
   logic           clk = 1'b0;
   logic           rst = 1'b1;
   logic           psel = 1'b0;
   logic           penable = 1'b0;
   logic           pwrite = 1'b0;
   logic [7:0]     paddr = 8'h00;
   logic [31:0]    pwdata = 32'h0;
   logic [31:0]    sp1 = 32'h0;
   logic [31:0]    sp2 = 32'h0;
   logic [1:0]     chg = 2'h0;
   logic [31:0]    prdata, rdat;
   logic           pready, pslverr, rerr;
   reading_t [1:0] rd, ctl, filt;
   linear_t [1:0]  lin;
   extreme_t [1:0] ext;
   int             n_mismatch = 0;
   int             checks_done = 0;

   always #2.5 clk = ~clk;

   reading_math_processor reading_math_processor_inst (
      .core_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .loop_one_setpoint_in(sp1),
      .loop_two_setpoint_in(sp2), .reading_in(rd), .input_change_in(chg),
      .control_reading_out(ctl), .filtered_out(filt), .linear_out(lin),
      .extreme_out(ext)
   );
   reading_source_model src_model (.core_clk_in(clk), .reading_out(rd));
   ////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      check(32'(n), 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
      // an idle edge, so the next setup never reassigns psel in this time step
      @(posedge clk);
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask : wr

   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      check(rdat, e);
   endtask : rd_reg

   function automatic logic [31:0] cfg(input int mm, x, eq, b, en, pts, win);
      return 32'((win << 16) | (pts << 9) | (en << 8) | (b << 5) | (eq << 4) | (x << 2) | mm);
   endfunction : cfg
   ////////////////////////////////////////
   task automatic t_defaults;
      rd_reg(`OFF_CFG, cfg(0, 0, 0, 0, 0, 8, 1));
      rd_reg(`OFF_FSCALE, `FSCALE_RESET);
      rd_reg(8'h44, 32'h0);
      check({31'h0, rerr}, 32'h1);
      wr(`OFF_CFG, cfg(3, 3, 1, 7, 0, 127, 15));
      rd_reg(`OFF_CFG, cfg(3, 0, 1, 0, 0, 64, 10));
      wr(`OFF_CFG, cfg(0, 0, 0, 0, 0, 1, 0));
      rd_reg(`OFF_CFG, cfg(0, 0, 0, 0, 0, 2, 1));
   endtask : t_defaults

   task automatic t_linear;
      int bt[5] = '{5, 100, -100, -30, 30};
      int x;
      int e;
      sp1 <= 32'd100;
      sp2 <= -32'sd30;
      wr(`OFF_GAIN, 32'h0002_0000);
      wr(`OFF_OFFS, 32'd5);
      for (int i = 0; i < 10; i++) begin
         wr(`OFF_CFG, cfg(3, i % 3, i / 5, i % 5, 0, 8, 1));
         src_model.send(0, 32'd10, 32'd20, 32'd30, 3);
         x = 10 * (i % 3 + 1);
         e = (i / 5) ? 2 * (x + bt[i % 5]) : 2 * x + bt[i % 5];
         check(lin[0].value, 32'(e));
         rd_reg(`OFF_LIN, 32'(e));
         check(ext[0].max, 32'(e));
      end
   endtask : t_linear

   task automatic t_extreme;
      logic [31:0] v[4] = '{32'd1, 32'd2, 32'd3, 32'd7};
      logic [31:0] s[4] = '{32'd50, -32'sd20, 32'd80, 32'd10};
      for (int i = 0; i < 4; i++) begin
         wr(`OFF_CFG, cfg(i, 0, 0, 0, 0, 8, 1));
         src_model.send(0, 32'd1, 32'd2, 32'd3, 3);
         check(ext[0].max, v[i]);
         check(ext[0].min, v[i]);
      end
      wr(`OFF_CFG, cfg(2, 0, 0, 0, 0, 8, 1));
      foreach (s[i]) src_model.send(0, s[i], s[i], s[i], 3);
      rd_reg(`OFF_MAX, 32'd80);
      rd_reg(`OFF_MIN, -32'sd20);
      check({31'h0, ext[1].seen}, 32'h0);
      wr(`OFF_CMD, 32'h1);
      repeat (2) @(posedge clk);
      check({31'h0, ext[0].seen}, 32'h0);
      rd_reg(`OFF_CFG, cfg(2, 0, 0, 0, 0, 8, 1));
      src_model.send(0, s[0], s[0], s[0], 3);
      check(ext[0].max, s[0]);
      chg <= 2'h1;
      @(posedge clk);
      chg <= 2'h0;
      repeat (2) @(posedge clk);
      check({31'h0, ext[0].seen}, 32'h0);
   endtask : t_extreme

   // window 10 % of 1000 gives a restart limit of 100, two points halve each step
   task automatic t_filter;
      logic [31:0] vin[4] = '{32'd100, 32'd180, 32'd60, 32'd700};
      logic [31:0] vexp[4] = '{32'd100, 32'd140, 32'd100, 32'd700};
      wr(`CH_STRIDE + `OFF_FSCALE, 32'd1000);
      wr(`CH_STRIDE + `OFF_CFG, cfg(2, 0, 0, 0, 1, 2, 10));
      @(posedge clk);
      foreach (vin[i]) begin
         src_model.send(1, vin[i], vin[i], vin[i], 3);
         check(filt[1].sensor, vexp[i]);
         check(filt[1].kelvin, vexp[i]);
      end
      check(ext[1].min, 32'd100);
      check(ext[1].max, 32'd700);
      wr(`CH_STRIDE + `OFF_CFG, cfg(2, 0, 0, 0, 0, 2, 10));
      @(posedge clk);
      src_model.send(1, 32'd333, 32'd333, 32'd333, 3);
      check(filt[1].celsius, 32'd333);
      rd_reg(`OFF_FSCALE, `FSCALE_RESET);
   endtask : t_filter

   // default length, 1 % of the reset full scale gives a limit of 1000
   task automatic t_settle;
      wr(`OFF_CFG, cfg(2, 0, 0, 0, 1, 8, 1));
      src_model.send(0, 32'd0, 32'd0, 32'd0, 1);
      for (int i = 0; i < 50; i++) begin
         src_model.send(0, 32'd1000, 32'd1000, 32'd1000, 1);
         if (i == 0) check(filt[0].sensor, 32'd125);
      end
      check({31'h0, filt[0].sensor > 32'd989 && filt[0].sensor < 32'd1001}, 32'h1);
      wr(`OFF_CMD, 32'h2);
      @(posedge clk);
      check({31'h0, ext[1].seen}, 32'h0);
      check({31'h0, ext[0].seen}, 32'h1);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      check({31'h0, ext[0].seen}, 32'h0);
   endtask : t_settle
   ////////////////////////////////////////
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_defaults();
      t_linear();
      t_extreme();
      t_filter();
      t_settle();
      complete_run();
   end

   // the tests need well under a thousand cycles; this allows five thousand
   initial begin
      #25000;
      n_mismatch++;
      complete_run();
   end
endmodule : tb_top
